// file: logic/ccf_pkg.sv
// Shared types and constants of the clock request and fault failsafe block.
package ccf_pkg;

  // ==========================================================================
  // Power modes
  // ==========================================================================
  // Operating mode reported by the power manager.
  typedef enum logic [2:0] {
    MODE_ACTIVE,
    MODE_SLEEP0,
    MODE_SLEEP3,
    MODE_SLEEP4,
    MODE_SHUT35,
    MODE_SHUT45
  } ccf_mode_e;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int ADDR_W = 4;  // Width of the register address.
  localparam int DATA_W = 16;  // Width of the register data.
  localparam logic [3:0] ADDR_CTRL = 4'h0;  // Control register.
  localparam logic [3:0] ADDR_STATUS = 4'h2;  // Fault flags, write one to clear.
  localparam logic [3:0] ADDR_TAP = 4'h4;  // Current DCO tap, read only.

  // Control register layout, most significant field first.
  typedef struct packed {
    logic crystalHf;  // Crystal runs in high-frequency mode.
    logic fllRefSelect;  // FLL reference select, zero picks the crystal.
    logic [1:0] auxSelect;  // Programmed auxiliary clock source.
    logic [1:0] submainSelect;  // Programmed sub-main clock source.
    logic [1:0] mainSelect;  // Programmed main clock source.
    logic crystalBypass;  // Crystal input is in bypass mode.
    logic irqEnable;  // Oscillator fault interrupt enable.
    logic failoverDisable;  // Disables auxiliary clock failover.
    logic osc_off_ctl;  // Auxiliary clock off control.
    logic submainOff;  // Sub-main clock off control.
    logic submainReqEn;  // Sub-main request enable.
    logic mainReqEn;  // Main request enable.
    logic auxReqEn;  // Auxiliary request enable.
  } ccf_ctrl_s;

  localparam logic [15:0] CTRL_RESET = 16'h0007;  // Request enables on.
  localparam int STAT_CRYSTAL = 0;  // Crystal fault flag bit.
  localparam int STAT_DCO = 1;  // DCO fault flag bit.
  localparam int STAT_IRQ = 2;  // Oscillator fault interrupt flag bit.

  // ==========================================================================
  // Clock sources and limits
  // ==========================================================================
  localparam logic [1:0] SRC_DCO_DIV = 2'h0;  // Divided DCO clock.
  localparam logic [1:0] SRC_INT_REF = 2'h1;  // Internal reference clock.
  localparam logic [1:0] SRC_CRYSTAL = 2'h2;  // Crystal oscillator.
  localparam logic [1:0] SRC_VLP = 2'h3;  // Very-low-power clock.
  localparam logic FLL_REF_CRYSTAL = 1'b0;  // FLL reference select for the crystal.
  localparam logic [8:0] DCO_TAP_MIN = 9'h000;  // Lowest DCO tap.
  localparam logic [8:0] DCO_TAP_MAX = 9'h1FF;  // Highest DCO tap.
  localparam int RECOVERY_LF = 8192;  // Recovery count, LF or bypass.
  localparam int RECOVERY_HF = 1024;  // Recovery count, HF.
  localparam int COUNT_W = 14;  // Width of the recovery counter.

  // ==========================================================================
  // Carriers
  // ==========================================================================
  // Peripheral clock requests.
  typedef struct packed {
    logic aux;
    logic main;
    logic submain;
  } ccf_req_s;

  // Clock gate enables.
  typedef struct packed {
    logic aux;
    logic main;
    logic submain;
    logic dcoDiv;
  } ccf_clk_en_s;

  // Effective clock sources after failover.
  typedef struct packed {
    logic [1:0] aux;
    logic [1:0] main;
    logic [1:0] submain;
  } ccf_src_s;

endpackage

// file: logic/ccf_sync.sv
// Two-stage synchroniser for a group of level inputs.
module ccf_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Levels in and out.
  input wire logic [WIDTH-1:0] levelIn,
  output logic [WIDTH-1:0] levelOut
);

  // ==========================================================================
  // State
  // ==========================================================================
  // Both stages; the first is read only by the second.
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } ccf_sync_s;

  ccf_sync_s state;  // Registered stages.
  ccf_sync_s next_state;  // Next stages.

  // Shift the input through both stages.
  always_comb begin
    next_state.first = levelIn;
    next_state.second = state.first;
  end

  // Register the stages; reset clears them.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign levelOut = state.second;

endmodule

// file: logic/ccf_top.sv
// Clock request gating and oscillator fault failsafe logic.

// How it works
// - Requests override off controls, bits unchanged.
// - Watchdog falls back to very-low-power clock.
// - Request enables reset on, per-clock clear.
// - Enabled request holds clock; aux and main requests block sleep.
// - Disabled request enable: mode and off controls decide.
// - Aux runs unless shutdown or off without request; main needs requests outside active mode.
// - Sub-main: off clear and mode, or request.
// - Shutdown allowed only with aux enable cleared.
// - Crystal fault flag sticky, re-sets while faulty.
// - LF crystal fault: internal reference feeds FLL.
// - HF crystal fault leaves FLL without reference.
// - Highest DCO tap also flags DCO fault.
// - DCO fault: tap extreme, unlocked, FLL enabled.
// - Fault irq flag set at reset, drives NMI.
// - Irq flag held during faults, software clears.
// - Main clock fails over, select kept.
// - Sub-main clock fails over, select kept.
// - Aux fails to reference unless disabled.
// - Backups revert once flag cleared, no fault.
// - Recovery counter releases crystal fault at maximum.
// - Divided DCO clock always runs.
module ccf_top #(
  parameter int LF_RECOVERY = ccf_pkg::RECOVERY_LF,
  parameter int HF_RECOVERY = ccf_pkg::RECOVERY_HF
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Register port.
  input wire logic [ccf_pkg::ADDR_W-1:0] regAddr,
  input wire logic [ccf_pkg::DATA_W-1:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [ccf_pkg::DATA_W-1:0] regReadData,
  // Peripheral clock requests, asynchronous.
  input wire ccf_pkg::ccf_req_s periphReq,
  // Power mode and oscillator status.
  input wire ccf_pkg::ccf_mode_e powerMode,
  input wire logic crystalEnabled,
  input wire logic crystalStopped,
  input wire logic wdtSourceOk,
  input wire logic fllEnabled,
  input wire logic fllLocked,
  input wire logic [8:0] dcoTap,
  // Clock gating and source selection.
  output ccf_pkg::ccf_clk_en_s clkEnable,
  output ccf_pkg::ccf_src_s clkSource,
  output logic wdtUseVlp,
  output logic fllRefInternal,
  output logic fllRefMissing,
  // Power manager and interrupt handshake.
  output logic sleepBlock,
  output logic shutdownAllowed,
  output logic nmiRequest
);

  // ==========================================================================
  // Constants
  // ==========================================================================
  localparam logic [ccf_pkg::COUNT_W-1:0] LF_MAX = ccf_pkg::COUNT_W'(LF_RECOVERY);
  localparam logic [ccf_pkg::COUNT_W-1:0] HF_MAX = ccf_pkg::COUNT_W'(HF_RECOVERY);
  localparam logic [ccf_pkg::COUNT_W-1:0] COUNT_ONE = 14'h0001;

  // ==========================================================================
  // Synchronisers
  // ==========================================================================
  ccf_pkg::ccf_req_s reqSync;  // Synchronised peripheral requests.
  logic stoppedSync;  // Synchronised crystal stop indication.
  logic wdtOkSync;  // Synchronised watchdog source status.
  logic lockedSync;  // Synchronised FLL lock status.

  // All asynchronous levels pass two flip-flops first.
  ccf_sync #(
    .WIDTH(6)
  ) uSync (
    .clock(clock),
    .rst_n(rst_n),
    .levelIn({periphReq, crystalStopped, wdtSourceOk, fllLocked}),
    .levelOut({reqSync, stoppedSync, wdtOkSync, lockedSync})
  );

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    ccf_pkg::ccf_ctrl_s ctrl;
    logic crystalFlag;
    logic dcoFlag;
    logic irqFlag;
    logic [ccf_pkg::COUNT_W-1:0] recovery;
    logic [ccf_pkg::DATA_W-1:0] readData;
    ccf_pkg::ccf_clk_en_s clkEn;
    ccf_pkg::ccf_src_s src;
    logic wdtVlp;
    logic refInternal;
    logic refMissing;
    logic block;
    logic shutOk;
    logic nmi;
  } ccf_state_s;

  ccf_state_s state;  // Registered state.
  ccf_state_s next_state;  // Next state.

  // Combinational helpers.
  logic recoveryMax;  // Counter has reached its mode's maximum.
  logic crystalCond;  // Crystal fault condition.
  logic dcoCond;  // DCO fault condition.
  logic failover;  // Backup sources are in use.
  logic running;  // Mode is not a shutdown mode.
  logic awake;  // Mode is active or sleep mode 0.
  logic [ccf_pkg::DATA_W-1:0] clearBits;  // Write-one-to-clear mask.
  logic [ccf_pkg::DATA_W-1:0] statusWord;  // Status as read back.
  logic [1:0] hfBackup;  // Backup for main and sub-main clocks.

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    next_state = state;
    // Register writes; flags are handled below.
    clearBits = '0;
    if (regWrite && regAddr == ccf_pkg::ADDR_CTRL) begin
      next_state.ctrl = ccf_pkg::ccf_ctrl_s'(regWriteData);
    end
    if (regWrite && regAddr == ccf_pkg::ADDR_STATUS) begin
      clearBits = regWriteData;
    end

    // Crystal recovery counter restarts on every fault.
    if (state.ctrl.crystalHf && !state.ctrl.crystalBypass) begin
      recoveryMax = (state.recovery >= HF_MAX);
    end else begin
      recoveryMax = (state.recovery >= LF_MAX);
    end
    if (crystalEnabled && stoppedSync) begin
      next_state.recovery = '0;
    end else if (!recoveryMax) begin
      next_state.recovery = state.recovery + COUNT_ONE;
    end

    // Fault conditions.
    crystalCond = crystalEnabled && (stoppedSync || !recoveryMax);
    dcoCond = fllEnabled && !lockedSync &&
      (dcoTap == ccf_pkg::DCO_TAP_MIN || dcoTap == ccf_pkg::DCO_TAP_MAX);

    // Sticky flags; a set in the clearing cycle wins.
    next_state.crystalFlag = crystalCond || (state.crystalFlag && !clearBits[ccf_pkg::STAT_CRYSTAL]);
    next_state.dcoFlag = dcoCond || (state.dcoFlag && !clearBits[ccf_pkg::STAT_DCO]);
    next_state.irqFlag = crystalCond || dcoCond ||
      (state.irqFlag && !clearBits[ccf_pkg::STAT_IRQ]);
    next_state.nmi = next_state.irqFlag && next_state.ctrl.irqEnable;

    // Backups stay until the irq or crystal flag is cleared with no crystal fault.
    failover = state.irqFlag && (state.crystalFlag || crystalCond);
    hfBackup = state.ctrl.crystalHf ? ccf_pkg::SRC_DCO_DIV : ccf_pkg::SRC_INT_REF;

    // Effective sources; the programmed selects are never altered.
    next_state.src.main = state.ctrl.mainSelect;
    if (failover && state.ctrl.mainSelect == ccf_pkg::SRC_CRYSTAL) begin
      next_state.src.main = hfBackup;
    end
    next_state.src.submain = state.ctrl.submainSelect;
    if (failover && state.ctrl.submainSelect == ccf_pkg::SRC_CRYSTAL) begin
      next_state.src.submain = hfBackup;
    end
    next_state.src.aux = state.ctrl.auxSelect;
    if (failover && !state.ctrl.failoverDisable &&
        state.ctrl.auxSelect == ccf_pkg::SRC_CRYSTAL) begin
      next_state.src.aux = ccf_pkg::SRC_INT_REF;
    end

    // FLL reference handling on a crystal fault.
    next_state.refInternal = crystalCond && !state.ctrl.crystalHf &&
      state.ctrl.fllRefSelect == ccf_pkg::FLL_REF_CRYSTAL;
    next_state.refMissing = crystalCond && state.ctrl.crystalHf &&
      state.ctrl.fllRefSelect == ccf_pkg::FLL_REF_CRYSTAL;

    // Watchdog takes the very-low-power clock when its source is gone.
    next_state.wdtVlp = !wdtOkSync;

    // Mode groups.
    running = !(powerMode == ccf_pkg::MODE_SHUT35 || powerMode == ccf_pkg::MODE_SHUT45);
    awake = (powerMode == ccf_pkg::MODE_ACTIVE || powerMode == ccf_pkg::MODE_SLEEP0);

    // Clock gates; requests override off controls only while enabled.
    next_state.clkEn.aux = running &&
      (!state.ctrl.osc_off_ctl || (state.ctrl.auxReqEn && reqSync.aux));
    next_state.clkEn.main = (powerMode == ccf_pkg::MODE_ACTIVE) ||
      (running && state.ctrl.mainReqEn && reqSync.main);
    next_state.clkEn.submain = (awake && !state.ctrl.submainOff) ||
      (running && state.ctrl.submainReqEn && reqSync.submain);
    next_state.clkEn.dcoDiv = 1'b1;

    // Power manager handshake.
    next_state.block = (state.ctrl.auxReqEn && reqSync.aux) ||
      (state.ctrl.mainReqEn && reqSync.main);
    next_state.shutOk = !state.ctrl.auxReqEn;

    // Read data stand only in the cycle after the read strobe.
    statusWord = '0;
    statusWord[ccf_pkg::STAT_CRYSTAL] = state.crystalFlag;
    statusWord[ccf_pkg::STAT_DCO] = state.dcoFlag;
    statusWord[ccf_pkg::STAT_IRQ] = state.irqFlag;
    next_state.readData = '0;
    if (regRead) begin
      case (regAddr)
        ccf_pkg::ADDR_CTRL: begin
          next_state.readData = state.ctrl;
        end
        ccf_pkg::ADDR_STATUS: begin
          next_state.readData = statusWord;
        end
        ccf_pkg::ADDR_TAP: begin
          next_state.readData = {7'h00, dcoTap};
        end
        default: begin
          next_state.readData = '0;
        end
      endcase
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Reset enables requests and raises the irq flag as at power-on.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= '0;
      state.ctrl <= ccf_pkg::CTRL_RESET;
      state.irqFlag <= 1'b1;
      state.clkEn.dcoDiv <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign regReadData = state.readData;
  assign clkEnable = state.clkEn;
  assign clkSource = state.src;
  assign wdtUseVlp = state.wdtVlp;
  assign fllRefInternal = state.refInternal;
  assign fllRefMissing = state.refMissing;
  assign sleepBlock = state.block;
  assign shutdownAllowed = state.shutOk;
  assign nmiRequest = state.nmi;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  // A requested aux clock runs even with its off control set.
  a_aux_override: assert property (@(posedge clock) disable iff (!rst_n)
    (state.ctrl.auxReqEn && reqSync.aux && running) |=> clkEnable.aux)
    else $error("Aux request did not override off control.");

  // Shutdown modes stop the aux, main and sub-main clocks.
  a_shutdown_off: assert property (@(posedge clock) disable iff (!rst_n)
    !running |=> !clkEnable.aux && !clkEnable.main && !clkEnable.submain)
    else $error("Clock running in shutdown mode.");

  // Disabled main request enable leaves main off in sleep modes.
  a_main_gated: assert property (@(posedge clock) disable iff (!rst_n)
    (powerMode != ccf_pkg::MODE_ACTIVE && !state.ctrl.mainReqEn) |=> !clkEnable.main)
    else $error("Main clock ran without request enable.");

  // Sub-main off with no enabled request means no sub-main clock.
  a_submain_off: assert property (@(posedge clock) disable iff (!rst_n)
    (state.ctrl.submainOff && !state.ctrl.submainReqEn) |=> !clkEnable.submain)
    else $error("Sub-main ran while off.");

  // A stuck crystal keeps its flag set despite clears.
  a_crystal_sticky: assert property (@(posedge clock) disable iff (!rst_n)
    (crystalEnabled && stoppedSync) |=> state.crystalFlag && state.irqFlag)
    else $error("Crystal fault flag lost.");

  // An extreme tap while unlocked sets the DCO flag.
  a_dco_fault: assert property (@(posedge clock) disable iff (!rst_n)
    (dcoCond && !state.dcoFlag) |=> state.dcoFlag)
    else $error("DCO fault not flagged.");

  // NMI follows flag and enable in the same cycle.
  a_nmi_request: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(state.irqFlag) && state.ctrl.irqEnable |-> nmiRequest)
    else $error("NMI not requested for fault flag.");

  // Main clock on the crystal fails over while faults stand.
  a_main_failover: assert property (@(posedge clock) disable iff (!rst_n)
    (failover && state.ctrl.mainSelect == ccf_pkg::SRC_CRYSTAL) |=>
      clkSource.main != ccf_pkg::SRC_CRYSTAL)
    else $error("Main clock stayed on faulty crystal.");

  // Recovery stays short of its maximum for 8 cycles after a stop.
  a_hf_recovery: assert property (@(posedge clock) disable iff (!rst_n)
    (crystalEnabled && stoppedSync) |=> !recoveryMax [*8])
    else $error("Recovery released too early.");

  // Shutdown is permitted from the cycle after aux enable is cleared.
  a_shutdown_gate: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(state.ctrl.auxReqEn) |=> shutdownAllowed)
    else $error("Shutdown gate wrong.");

  // A live fault keeps the irq flag set.
  a_irq_held: assert property (@(posedge clock) disable iff (!rst_n)
    (crystalCond || dcoCond) |=> state.irqFlag)
    else $error("Irq flag not held.");

  // A missing watchdog source selects the very-low-power clock.
  a_wdt_fallback: assert property (@(posedge clock) disable iff (!rst_n)
    !wdtOkSync |=> wdtUseVlp)
    else $error("Watchdog fallback missing.");

  // An enabled main request blocks sleep entry.
  a_main_block: assert property (@(posedge clock) disable iff (!rst_n)
    (state.ctrl.mainReqEn && reqSync.main) |=> sleepBlock)
    else $error("Main request did not block sleep.");

  // Clearing the DCO flag with no fault leaves it clear.
  a_dco_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (regWrite && regAddr == ccf_pkg::ADDR_STATUS && regWriteData[ccf_pkg::STAT_DCO] &&
      !dcoCond) |=> !state.dcoFlag)
    else $error("DCO flag not cleared.");

  // Without failover the programmed selects drive the main and aux clocks.
  a_source_revert: assert property (@(posedge clock) disable iff (!rst_n)
    (!failover && !regWrite) |=>
      clkSource.main == state.ctrl.mainSelect && clkSource.aux == state.ctrl.auxSelect)
    else $error("Backup source kept.");

  // Aux on the crystal fails over unless disabled.
  a_aux_failover: assert property (@(posedge clock) disable iff (!rst_n)
    (failover && !state.ctrl.failoverDisable && state.ctrl.auxSelect == ccf_pkg::SRC_CRYSTAL)
      |=> clkSource.aux == ccf_pkg::SRC_INT_REF)
    else $error("Aux stayed on crystal.");

endmodule

// file: test/ccf_periph_model.sv
// Peripheral modules that raise clock requests from their enable and clock choice.
module ccf_periph_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Per-module enable and clock choice (0 aux, 1 main, 2 sub-main, 3 none).
  input wire logic [2:0] modOn,
  input wire logic [5:0] modSel,
  // Requests towards the clock block.
  output ccf_pkg::ccf_req_s req
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Request generation
  // ==========================================================================
  // Each enabled module raises the line of the clock it has chosen, after an edge.
  always @(posedge clock) begin
    logic [2:0] lines;
    lines = 3'h0;
    for (int k = 0; k < 3; k++) begin
      if (modOn[k] && modSel[2*k +: 2] != 2'h3) begin
        lines[2 - modSel[2*k +: 2]] = 1'b1;
      end
    end
    req <= rst_n ? lines : 3'h0;
  end
endmodule

// file: test/tb.sv
// Self-checking bench of the clock request and fault failsafe block.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LF = 16;  // Shortened low-frequency recovery count.
  localparam int HF = 8;  // Shortened high-frequency recovery count.

  // ==========================================================================
  // Signals
  // ==========================================================================
  logic clock = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWriteData = 16'h0000, regReadData, rdData;
  logic [2:0] modOn = 3'h0;
  logic [5:0] modSel = 6'h3F;
  ccf_pkg::ccf_req_s periphReq;
  ccf_pkg::ccf_mode_e powerMode = ccf_pkg::MODE_ACTIVE;
  logic crystalEnabled = 1'b0, crystalStopped = 1'b0, wdtSourceOk = 1'b1;
  logic fllEnabled = 1'b0, fllLocked = 1'b1;
  logic [8:0] dcoTap = 9'h0AB;
  ccf_pkg::ccf_clk_en_s clkEnable;
  ccf_pkg::ccf_src_s clkSource;
  logic wdtUseVlp, fllRefInternal, fllRefMissing, sleepBlock, shutdownAllowed, nmiRequest;
  ccf_pkg::ccf_ctrl_s ctrl;
  logic [2:0] expReq;
  int fails = 0, checksDone = 0, seedDummy;

  // Clock of 4 ns period.
  always #2 clock = ~clock;

  // ==========================================================================
  // Instances
  // ==========================================================================
  ccf_periph_model i_ccf_periph_model (.clock(clock), .rst_n(rst_n), .modOn(modOn),
    .modSel(modSel), .req(periphReq));
  ccf_top #(.LF_RECOVERY(LF), .HF_RECOVERY(HF)) i_ccf_top (.clock(clock), .rst_n(rst_n),
    .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .periphReq(periphReq), .powerMode(powerMode),
    .crystalEnabled(crystalEnabled), .crystalStopped(crystalStopped),
    .wdtSourceOk(wdtSourceOk), .fllEnabled(fllEnabled), .fllLocked(fllLocked),
    .dcoTap(dcoTap), .clkEnable(clkEnable), .clkSource(clkSource), .wdtUseVlp(wdtUseVlp),
    .fllRefInternal(fllRefInternal), .fllRefMissing(fllRefMissing),
    .sleepBlock(sleepBlock), .shutdownAllowed(shutdownAllowed), .nmiRequest(nmiRequest));

  // ==========================================================================
  // Tasks and model
  // ==========================================================================
  // Prints the counts and the verdict, then stops.
  task automatic finishTest();
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Compares a word-sized result.
  task automatic chkVal(input logic [15:0] got, input logic [15:0] exp, input string what);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Compares a single flag.
  task automatic chkFlag(input logic got, input logic exp, input string what);
    chkVal({15'h0000, got}, {15'h0000, exp}, what);
  endtask

  // Waits n edges, then steps past the edge so outputs are settled.
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // One-cycle register write.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  // One-cycle register read; the data stand in the following cycle only.
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    rdData = regReadData;
  endtask

  // Expected gate enables from mode, control low bits and requests.
  function automatic logic [3:0] expEn(ccf_pkg::ccf_mode_e m, logic [4:0] c, logic [2:0] r);
    logic sd, run;
    sd = (m == ccf_pkg::MODE_SHUT35) || (m == ccf_pkg::MODE_SHUT45);
    run = (m == ccf_pkg::MODE_ACTIVE) || (m == ccf_pkg::MODE_SLEEP0);
    return {!sd && (!c[4] || (c[0] && r[2])), !sd && ((m == ccf_pkg::MODE_ACTIVE)
      || (c[1] && r[1])), !sd && ((!c[3] && run) || (c[2] && r[0])), 1'b1};
  endfunction

  // Hang guard.
  initial begin
    repeat (30000) @(posedge clock);
    fails++;
    $display("[FAIL] %0t run did not finish", $time);
    finishTest();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic [15:0] dt [5];
    seedDummy = $urandom(90421);
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    cyc(2);
    rd(ccf_pkg::ADDR_CTRL);
    chkVal(rdData, 16'h0007, "ctrl reset");
    rd(ccf_pkg::ADDR_STATUS);
    chkVal(rdData, 16'h0004, "status reset");
    rd(4'h6);
    chkVal(rdData, 16'h0000, "unmapped read");
    wr(ccf_pkg::ADDR_TAP, 16'hFFFF);
    rd(ccf_pkg::ADDR_TAP);
    chkVal(rdData, 16'h00AB, "tap read only");
    wr(ccf_pkg::ADDR_STATUS, 16'h0007);
    // Watchdog fallback follows the availability of its source.
    for (int v = 0; v < 2; v++) begin
      @(posedge clock);
      wdtSourceOk <= v[0];
      cyc(5);
      chkFlag(wdtUseVlp, !v[0], "watchdog source");
    end
    // Random modes, request enables, off controls and peripheral requests.
    for (int i = 0; i < 60; i++) begin
      ctrl = '0;
      {ctrl.osc_off_ctl, ctrl.submainOff, ctrl.submainReqEn, ctrl.mainReqEn, ctrl.auxReqEn} =
        5'($urandom_range(0, 31));
      @(posedge clock);
      modOn <= 3'($urandom_range(0, 7));
      modSel <= 6'($urandom_range(0, 63));
      powerMode <= ccf_pkg::ccf_mode_e'($urandom_range(0, 5));
      wr(ccf_pkg::ADDR_CTRL, ctrl);
      cyc(6);
      expReq = 3'h0;
      for (int k = 0; k < 3; k++) begin
        if (modOn[k] && modSel[2*k +: 2] != 2'h3) expReq[2 - modSel[2*k +: 2]] = 1'b1;
      end
      chkVal(clkEnable, expEn(powerMode, ctrl[4:0], expReq), "gates");
      chkFlag(sleepBlock, (ctrl.auxReqEn && expReq[2]) || (ctrl.mainReqEn && expReq[1]),
        "sleep block");
      chkFlag(shutdownAllowed, !ctrl.auxReqEn, "shutdown allowed");
      rd(ccf_pkg::ADDR_CTRL);
      chkVal(rdData, ctrl, "ctrl kept");
    end
    // DCO fault cases: enable, lock, tap, expected status after a clear.
    dt = '{16'h1000, 16'h11FF, 16'h1100, 16'h0000, 16'h31FF};
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      {fllLocked, fllEnabled} <= dt[i][13:12];
      dcoTap <= dt[i][8:0];
      cyc(5);
      wr(ccf_pkg::ADDR_STATUS, 16'h0007);
      cyc(3);
      rd(ccf_pkg::ADDR_STATUS);
      chkVal(rdData, (dt[i][13:12] == 2'h1 && (dt[i][8:0] == 9'h000 || dt[i][8:0] == 9'h1FF))
        ? 16'h0006 : 16'h0000, "dco fault");
    end
    // Crystal fault in low- then high-frequency mode, every clock on the crystal.
    for (int hf = 0; hf < 2; hf++) begin
      ctrl = '0;
      {ctrl.crystalHf, ctrl.failoverDisable, ctrl.irqEnable} = {hf[0], hf[0], 1'b1};
      {ctrl.auxSelect, ctrl.submainSelect, ctrl.mainSelect} = {3{ccf_pkg::SRC_CRYSTAL}};
      ctrl[2:0] = 3'h7;
      wr(ccf_pkg::ADDR_CTRL, ctrl);
      crystalEnabled <= 1'b1;
      crystalStopped <= 1'b1;
      cyc(6);
      wr(ccf_pkg::ADDR_STATUS, 16'h0007);
      cyc(3);
      rd(ccf_pkg::ADDR_STATUS);
      chkVal(rdData, 16'h0005, "crystal fault re-set");
      chkVal(clkSource, {hf[0] ? ccf_pkg::SRC_CRYSTAL : ccf_pkg::SRC_INT_REF,
        {2{hf[0] ? ccf_pkg::SRC_DCO_DIV : ccf_pkg::SRC_INT_REF}}}, "failover");
      chkFlag(fllRefInternal, !hf[0], "fll internal ref");
      chkFlag(fllRefMissing, hf[0], "fll ref missing");
      chkFlag(nmiRequest, 1'b1, "nmi raised");
      chkFlag(clkEnable.dcoDiv, 1'b1, "dco divided runs");
      @(posedge clock);
      crystalStopped <= 1'b0;
      cyc(3 + (hf[0] ? HF : LF) / 2);
      wr(ccf_pkg::ADDR_STATUS, 16'h0007);
      rd(ccf_pkg::ADDR_STATUS);
      chkVal(rdData, 16'h0005, "recovery pending");
      cyc(hf[0] ? HF : LF);
      wr(ccf_pkg::ADDR_STATUS, 16'h0007);
      cyc(3);
      rd(ccf_pkg::ADDR_STATUS);
      chkVal(rdData, 16'h0000, "recovered");
      chkVal(clkSource, {3{ccf_pkg::SRC_CRYSTAL}}, "revert");
      chkFlag(nmiRequest, 1'b0, "nmi dropped");
      rd(ccf_pkg::ADDR_CTRL);
      chkVal(rdData, ctrl, "selects and irq enable kept");
      @(posedge clock);
      crystalEnabled <= 1'b0;
    end
    finishTest();
  end
endmodule
